// *** hdl/spm_defs.svh ***
// Purpose: constants of the system protection monitors
// Assumes: 32-bit AXI4-Lite register window
// Notes: offsets are byte addresses
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SPM_PCR_OFS 12'h000
`define SPM_WSR_OFS 12'h004
`define SPM_RCR_OFS 12'h008
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SPM_BTS_LSB 0
`define SPM_BME_BIT 2
`define SPM_HME_BIT 3
`define SPM_WDE_BIT 4
`define SPM_PCR_RST 5'h08
`define SPM_CAUSE_HALT_BIT 0
`define SPM_CAUSE_WDOG_BIT 1
// ----------------------------------------
// timing counts in system clocks
// ----------------------------------------
`define SPM_BM_CLK_00 7'h40
`define SPM_BM_CLK_01 7'h20
`define SPM_BM_CLK_10 7'h10
`define SPM_BM_CLK_11 7'h08
`define SPM_WDOG_CYCLES 65536
// ----------------------------------------
// service sequence values and responses
// ----------------------------------------
`define SPM_SVC_FIRST 8'h55
`define SPM_SVC_SECOND 8'hAA
`define SPM_RESP_OKAY 2'h0
`define SPM_RESP_SLVERR 2'h2
`endif

// *** hdl/spm_pkg.sv ***
// Purpose: types of the system protection monitors
// Assumes: constants live in spm_defs.svh
// Notes: none
package spm_pkg;
	// ----------------------------------------
	// control fields and external bus view
	// ----------------------------------------
	typedef struct packed {
		logic wd_en;
		logic hm_en;
		logic bm_en;
		logic [1:0] bts;
	} spm_ctrl_t;
	typedef struct packed {
		logic cyc_active;
		logic cpu_owned;
		logic size_ack;
		logic word_to_byte;
	} spm_bus_t;
	typedef struct packed {
		logic iack_arb;
		logic iack_end;
	} spm_irq_t;
	typedef enum logic [1:0] {
		SPM_SVC_IDLE = 2'b01,
		SPM_SVC_ARMED = 2'b10
	} spm_svc_t;
endpackage : spm_pkg

// *** hdl/spm_top.sv ***
// Purpose: bus, halt, spurious interrupt and watchdog monitors
// Assumes: all inputs synchronous to clk
// Notes: registers over AXI4-Lite
//
// Behaviour
// - the timeout select picks 64, 32, 16 or 8 clocks for codes 00, 01, 10, 11.
// - the bus monitor only watches cycles that the processor starts.
// - the bus monitor enable bit turns internal-to-external monitoring on and off.
// - for a word to an 8-bit port the count restarts only after both bytes.
// - a halt from a double bus fault makes a reset and records its cause.
// - with the halt monitor enable clear, the halt reset is suppressed.
// - interrupt processing without arbitration raises the bus error.
// - the spurious interrupt monitor cannot be turned off.
// - the watchdog runs only while its enable bit is set.
// - an unserviced enabled watchdog times out and asserts reset.
// - writing 55 then AA to the service register restarts the watchdog.
`timescale 1ns/10ps
`include "spm_defs.svh"
module spm_top import spm_pkg::*; #(
	parameter int WDOG_CYCLES = `SPM_WDOG_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [11:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [11:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire spm_bus_t ext_bus,
	input wire spm_irq_t irq,
	input wire logic halt,
	output logic bus_error,
	output logic chip_reset
);
	// ----------------------------------------
	// register slave
	// ----------------------------------------
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	spm_ctrl_t ctrl;
	logic [1:0] reset_cause;
	wire do_write = !s_awready && !s_wready && !s_bvalid;
	wire wr_pcr = do_write && aw_addr == `SPM_PCR_OFS && w_strb[0];
	wire wr_svc = do_write && aw_addr == `SPM_WSR_OFS && w_strb[0];
	wire wr_hit = aw_addr == `SPM_PCR_OFS || aw_addr == `SPM_WSR_OFS || aw_addr == `SPM_RCR_OFS;
	wire [7:0] svc_data = w_data[7:0];
	logic [31:0] rd_val;
	logic rd_hit;
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		if (s_araddr == `SPM_PCR_OFS) begin
			rd_val = {27'h000_0000, ctrl};
		end else if (s_araddr == `SPM_RCR_OFS) begin
			rd_val = {30'h0000_0000, reset_cause};
		end else if (s_araddr != `SPM_WSR_OFS) begin
			rd_hit = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_awready <= 1'b1;
			s_wready <= 1'b1;
			s_bvalid <= 1'b0;
			s_bresp <= `SPM_RESP_OKAY;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_awvalid && s_awready) begin
				s_awready <= 1'b0;
				aw_addr <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				s_wready <= 1'b0;
				w_data <= s_wdata;
				w_strb <= s_wstrb;
			end
			if (do_write) begin
				s_bvalid <= 1'b1;
				s_bresp <= wr_hit ? `SPM_RESP_OKAY : `SPM_RESP_SLVERR;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
				s_awready <= 1'b1;
				s_wready <= 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_arready <= 1'b1;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= `SPM_RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b1;
			s_rdata <= rd_val;
			s_rresp <= rd_hit ? `SPM_RESP_OKAY : `SPM_RESP_SLVERR;
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
			s_arready <= 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl <= `SPM_PCR_RST;
		end else if (wr_pcr) begin
			ctrl <= w_data[4:0];
		end
	end
	// ----------------------------------------
	// bus monitor
	// ----------------------------------------
	logic [6:0] bm_count;
	logic bm_half;
	logic [6:0] bm_limit;
	always_comb begin
		case (ctrl.bts)
			2'b00: bm_limit = `SPM_BM_CLK_00;
			2'b01: bm_limit = `SPM_BM_CLK_01;
			2'b10: bm_limit = `SPM_BM_CLK_10;
			default: bm_limit = `SPM_BM_CLK_11;
		endcase
	end
	// only processor cycles, only when enabled
	wire bm_watch = ctrl.bm_en && ext_bus.cyc_active && ext_bus.cpu_owned;
	// first byte of a word to an 8-bit port keeps counting
	wire bm_first_byte = ext_bus.size_ack && ext_bus.word_to_byte && !bm_half;
	wire bm_done = ext_bus.size_ack && !bm_first_byte;
	wire bm_fire = bm_watch && !bm_done && bm_count == bm_limit - 7'h01;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bm_count <= 7'h00;
			bm_half <= 1'b0;
		end else if (!bm_watch || bm_done || bm_fire) begin
			bm_count <= 7'h00;
			bm_half <= 1'b0;
		end else begin
			bm_count <= bm_count + 7'h01;
			if (bm_first_byte) begin
				bm_half <= 1'b1;
			end
		end
	end
	// ----------------------------------------
	// spurious interrupt monitor
	// ----------------------------------------
	logic arb_seen;
	wire spur_fire = irq.iack_end && !arb_seen && !irq.iack_arb;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			arb_seen <= 1'b0;
		end else if (irq.iack_end) begin
			arb_seen <= 1'b0;
		end else if (irq.iack_arb) begin
			arb_seen <= 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_error <= 1'b0;
		end else begin
			bus_error <= bm_fire || spur_fire;
		end
	end
	// ----------------------------------------
	// software watchdog
	// ----------------------------------------
	spm_svc_t svc_state;
	spm_svc_t next_svc_state;
	logic [19:0] wd_count;
	always_comb begin
		next_svc_state = svc_state;
		case (svc_state)
			SPM_SVC_IDLE: begin
				if (wr_svc && svc_data == `SPM_SVC_FIRST) begin
					next_svc_state = SPM_SVC_ARMED;
				end
			end
			SPM_SVC_ARMED: begin
				if (wr_svc) begin
					next_svc_state = SPM_SVC_IDLE;
				end
			end
			default: next_svc_state = SPM_SVC_IDLE;
		endcase
	end
	wire svc_done = svc_state == SPM_SVC_ARMED && wr_svc && svc_data == `SPM_SVC_SECOND;
	wire wd_fire = ctrl.wd_en && !svc_done && wd_count == 20'(WDOG_CYCLES - 1);
	wire halt_fire = halt && ctrl.hm_en;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			svc_state <= SPM_SVC_IDLE;
		end else begin
			svc_state <= next_svc_state;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst || !ctrl.wd_en || svc_done || wd_fire) begin
			wd_count <= 20'h0_0000;
		end else begin
			wd_count <= wd_count + 20'h0_0001;
		end
	end
	// ----------------------------------------
	// reset generation and cause
	// ----------------------------------------
	// cause of the last produced reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			chip_reset <= 1'b0;
			reset_cause <= 2'b00;
		end else begin
			chip_reset <= halt_fire || wd_fire;
			if (halt_fire || wd_fire) begin
				reset_cause <= {wd_fire, halt_fire};
			end
		end
	end
	// ----------------------------------------
	// assertion helpers
	// ----------------------------------------
	// first service write seen
	logic svc_pending;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			svc_pending <= 1'b0;
		end else if (wr_svc) begin
			svc_pending <= !svc_pending && svc_data == `SPM_SVC_FIRST;
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_svc_first;
		!svc_pending && wr_svc && svc_data == `SPM_SVC_FIRST;
	endsequence
	sequence s_svc_second;
		svc_pending && wr_svc && svc_data == `SPM_SVC_SECOND;
	endsequence
	sequence s_svc_wrong;
		svc_pending && wr_svc && svc_data != `SPM_SVC_SECOND;
	endsequence
	AST_BM_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
		bm_fire |-> bm_count + 7'h01 == (`SPM_BM_CLK_00 >> ctrl.bts))
		else $error("bus monitor fired at wrong count");
	AST_BM_CPU_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
		!ext_bus.cpu_owned |=> bm_count == 7'h00) else $error("bus monitor counted a foreign cycle");
	AST_BM_ENABLE: assert property (@(posedge clk) disable iff (sys_rst)
		!ctrl.bm_en |-> !bm_fire) else $error("bus monitor fired while disabled");
	AST_BM_WORD: assert property (@(posedge clk) disable iff (sys_rst)
		bm_watch && bm_first_byte && !bm_fire |=> bm_half && bm_count != 7'h00)
		else $error("bus monitor restarted after first byte");
	AST_BM_ERR: assert property (@(posedge clk) disable iff (sys_rst)
		bm_watch && !ext_bus.size_ack && bm_count == bm_limit - 7'h01 |=> bus_error)
		else $error("bus monitor timeout gave no bus error");
	AST_HALT_RST: assert property (@(posedge clk) disable iff (sys_rst)
		halt && ctrl.hm_en |=> chip_reset && reset_cause[`SPM_CAUSE_HALT_BIT])
		else $error("halt gave no reset or cause");
	AST_HALT_OFF: assert property (@(posedge clk) disable iff (sys_rst)
		!ctrl.hm_en && !wd_fire |=> !chip_reset) else $error("halt reset while inhibited");
	AST_SPURIOUS: assert property (@(posedge clk) disable iff (sys_rst)
		irq.iack_end && !irq.iack_arb && !arb_seen |=> bus_error)
		else $error("spurious interrupt gave no bus error");
	AST_WD_OFF: assert property (@(posedge clk) disable iff (sys_rst)
		!ctrl.wd_en |=> wd_count == 20'h0_0000) else $error("watchdog ran while disabled");
	AST_WD_EXPIRE: assert property (@(posedge clk) disable iff (sys_rst)
		ctrl.wd_en && !svc_done && wd_count == 20'(WDOG_CYCLES - 1) |=> chip_reset
		&& reset_cause[`SPM_CAUSE_WDOG_BIT]) else $error("watchdog expiry gave no reset");
	AST_WD_ARM: assert property (@(posedge clk) disable iff (sys_rst)
		s_svc_first |=> svc_state == SPM_SVC_ARMED) else $error("first service write did not arm");
	AST_WD_SERVICE: assert property (@(posedge clk) disable iff (sys_rst)
		s_svc_second |=> wd_count == 20'h0_0000)
		else $error("service sequence did not restart watchdog");
	AST_WD_BAD_SEQ: assert property (@(posedge clk) disable iff (sys_rst)
		s_svc_wrong |-> !svc_done ##1 svc_state == SPM_SVC_IDLE)
		else $error("bad service sequence accepted");
endmodule : spm_top

// *** sim/spm_far.sv ***
// Purpose: far-side model, external bus slave and processor acknowledge
// Assumes: bench drives controls by non-blocking assignment at clk rise
// Notes: ack_gap of zero means the slave never acknowledges
`timescale 1ns/10ps
module spm_far import spm_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic go,
	input wire logic cpu,
	input wire logic w2b,
	input wire logic [7:0] ack_gap,
	input wire logic ack_req,
	input wire logic arb_en,
	output spm_bus_t ext_bus,
	output spm_irq_t irq
);
	logic [7:0] cnt;
	logic [1:0] req_d;
	wire ack_hit = (ack_gap != 8'h00) && ((cnt % ack_gap) == (ack_gap - 8'h01));
	// ----------------------------------------
	// external bus slave
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst || !go) begin
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
	assign ext_bus.cyc_active = go;
	assign ext_bus.cpu_owned = cpu;
	assign ext_bus.word_to_byte = w2b;
	assign ext_bus.size_ack = go && ack_hit;
	// ----------------------------------------
	// processor acknowledge window
	// ----------------------------------------
	always_ff @(posedge clk) begin
		req_d <= sys_rst ? 2'b00 : {req_d[0], ack_req};
	end
	assign irq.iack_arb = req_d[0] && arb_en;
	assign irq.iack_end = req_d[1];
endmodule : spm_far

// *** sim/spm_top_tb.sv ***
// Purpose: self-checking bench of the protection monitors
// Assumes: watchdog period shortened to 40 clocks
// Notes: bus error and reset pulses are counted continuously
`timescale 1ns/10ps
`include "spm_defs.svh"
module spm_top_tb import spm_pkg::*; ;
	localparam logic [11:0] PCR = `SPM_PCR_OFS;
	localparam logic [11:0] WSR = `SPM_WSR_OFS;
	localparam logic [11:0] RCR = `SPM_RCR_OFS;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [11:0] s_awaddr = 12'h000;
	logic [11:0] s_araddr = 12'h000;
	logic [31:0] s_wdata = 32'h0000_0000;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic halt = 1'b0, go = 1'b0, cpu = 1'b1, w2b = 1'b0, ack_req = 1'b0, arb_en = 1'b0;
	logic [7:0] ack_gap = 8'h00;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, bus_error, chip_reset;
	logic [1:0] s_bresp, s_rresp, r;
	logic [31:0] s_rdata, d;
	spm_bus_t ext_bus;
	spm_irq_t irq;
	int miscompares = 0, checks_done = 0, bus_error_seen = 0, rst_seen = 0, b, lim;
	spm_top #(.WDOG_CYCLES(40)) i_spm_top (.clk(clk), .sys_rst(sys_rst), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.ext_bus(ext_bus), .irq(irq), .halt(halt), .bus_error(bus_error), .chip_reset(chip_reset));
	spm_far i_spm_far (.clk(clk), .sys_rst(sys_rst), .go(go), .cpu(cpu), .w2b(w2b), .ack_gap(ack_gap),
		.ack_req(ack_req), .arb_en(arb_en), .ext_bus(ext_bus), .irq(irq));
	// ----------------------------------------
	// clock, pulse counters, hang guard
	// ----------------------------------------
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		if (bus_error === 1'b1) bus_error_seen <= bus_error_seen + 1;
		if (chip_reset === 1'b1) rst_seen <= rst_seen + 1;
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("BAD timeout at %0t", $time);
		report_and_stop();
	end
	// ----------------------------------------
	// access and compare tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rsp);
		@(posedge clk);
		s_awaddr <= a;
		s_wdata <= v;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1);
		s_bready <= 1'b0;
		rsp = s_bresp;
	endtask : wr
	task rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
		@(posedge clk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_arready) s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1);
		s_rready <= 1'b0;
		v = s_rdata;
		rsp = s_rresp;
	endtask : rd
	task wrc(input logic [11:0] a, input logic [31:0] v);
		wr(a, v, r);
		chk({30'h0, r}, 32'h0000_0000);
	endtask : wrc
	task rdc(input logic [11:0] a, input logic [31:0] e);
		rd(a, d, r);
		chk(d, e);
		chk({30'h0, r}, 32'h0000_0000);
	endtask : rdc
	// bus cycle, error count checked after n1 and again after n1+n2 clocks
	task tmo(input logic c, input logic w, input logic [7:0] g, input int n1, e1, n2, e2);
		go <= 1'b1;
		cpu <= c;
		w2b <= w;
		ack_gap <= g;
		b = bus_error_seen;
		repeat (n1) @(posedge clk);
		chk(bus_error_seen - b, e1);
		repeat (n2) @(posedge clk);
		chk(bus_error_seen - b, e2);
		go <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : tmo
	task pulse_try(input logic is_halt, input logic arb, input int e);
		b = is_halt ? rst_seen : bus_error_seen;
		halt <= is_halt;
		ack_req <= !is_halt;
		arb_en <= arb;
		@(posedge clk);
		halt <= 1'b0;
		ack_req <= 1'b0;
		repeat (5) @(posedge clk);
		chk((is_halt ? rst_seen : bus_error_seen) - b, e);
	endtask : pulse_try
	task report_and_stop();
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		rdc(PCR, 32'h0000_0008);
		rdc(RCR, 32'h0000_0000);
		rd(12'h00c, d, r);
		chk({30'h0, r}, 32'h0000_0002);
		wr(12'h010, 32'h0000_001f, r);
		chk({30'h0, r}, 32'h0000_0002);
		rdc(PCR, 32'h0000_0008);
		$display("register test done");
		for (int k = 0; k < 4; k++) begin
			lim = 64 >> k;
			wrc(PCR, 32'h0000_000c + 32'(k));
			rdc(PCR, 32'h0000_000c + 32'(k));
			tmo(1'b1, 1'b0, 8'h00, lim - 2, 0, 5, 1);
		end
		tmo(1'b1, 1'b1, 8'h05, 6, 0, 5, 1);
		tmo(1'b1, 1'b0, 8'h05, 6, 0, 14, 0);
		tmo(1'b0, 1'b0, 8'h00, 6, 0, 14, 0);
		wrc(PCR, 32'h0000_000b);
		tmo(1'b1, 1'b0, 8'h00, 6, 0, 14, 0);
		$display("bus monitor test done");
		wrc(PCR, 32'h0000_0000);
		pulse_try(1'b0, 1'b0, 1);
		pulse_try(1'b0, 1'b1, 0);
		$display("spurious test done");
		wrc(PCR, 32'h0000_0008);
		pulse_try(1'b1, 1'b0, 1);
		rdc(RCR, 32'h0000_0001);
		wrc(RCR, 32'h0000_0003);
		rdc(RCR, 32'h0000_0001);
		wrc(PCR, 32'h0000_0000);
		pulse_try(1'b1, 1'b0, 0);
		$display("halt test done");
		wrc(PCR, 32'h0000_0010);
		b = rst_seen;
		repeat (30) @(posedge clk);
		chk(rst_seen - b, 0);
		repeat (15) @(posedge clk);
		chk(rst_seen - b, 1);
		rdc(RCR, 32'h0000_0002);
		b = rst_seen;
		for (int k = 0; k < 4; k++) begin
			wrc(WSR, 32'h0000_0055);
			rdc(WSR, 32'h0000_0000);
			wrc(WSR, 32'h0000_00aa);
			repeat (20) @(posedge clk);
		end
		chk(rst_seen - b, 0);
		wrc(WSR, 32'h0000_0055);
		wrc(WSR, 32'h0000_0012);
		wrc(WSR, 32'h0000_00aa);
		repeat (35) @(posedge clk);
		chk(rst_seen - b, 1);
		wrc(PCR, 32'h0000_0000);
		b = rst_seen;
		repeat (60) @(posedge clk);
		chk(rst_seen - b, 0);
		$display("watchdog test done");
		report_and_stop();
	end
endmodule : spm_top_tb
